//--- serial_map.vh
// register map and timing constants of the serial transceiver
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
// byte offsets on the register bus
`define OFS_DATA 12'h000
`define OFS_CSA 12'h004
`define OFS_CSB 12'h008
`define OFS_BAUD 12'h00C
`define OFS_PORT 12'h010
// ctrl_status_a fields
`define CSA_RX_DONE 7
`define CSA_TX_DONE 6
`define CSA_DATA_EMPTY 5
`define CSA_FRAME_ERR 4
`define CSA_OVERRUN 3
`define CSA_DOUBLE 1
// ctrl_status_b fields
`define CSB_RX_EN 4
`define CSB_TX_EN 3
`define CSB_NINE 2
`define CSB_RX_NINTH 1
`define CSB_TX_NINTH 0
// general i/o port register fields
`define PORT_DIR_TX 0
`define PORT_DIR_RX 1
`define PORT_OUT_TX 2
`define PORT_OUT_RX 3
// reset values
`define CSA_RESET 8'h20
`define CSB_RESET 8'h02
`define BAUD_RESET 12'h000
// sampling constants
`define OVS_NORMAL 5'd16
`define OVS_DOUBLE 5'd8
`define SMP_A_NORMAL 5'd7
`define SMP_A_DOUBLE 5'd3
`endif

//--- serial_xcvr.v
// asynchronous serial transceiver channel with apb register access
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "serial_map.vh"

// Operation
// - data port write starts transmission
// - idle shifter loads from buffer immediately
// - busy shifter loads after stop bit
// - buffer-to-shifter move sets data-empty flag
// - load frames start zero, stop one
// - nine-bit mode copies tx ninth bit
// - start, data lsb first, then stop
// - data-empty stays set until next write
// - tx done after full stop bit
// - transmitter enable forces tx pin output
// - receiver samples at sixteen times baud
// - idle low sample starts start detection
// - majority of samples 8-10 rejects noise
// - data bits by majority, shifted in
// - stop majority zero sets framing error
// - frame loads buffer, sets rx done unless rx done set and unread
// - data port reads rx, writes tx
// - nine-bit mode stores received ninth bit
// - overrun loses char, flag after read
// - receiver enable forces rx pin input
// - nine-bit frames carry nine data bits
// - double speed halves oversampling to eight
// - reading data port clears rx done
// - writing one clears tx done
// - data-empty set during reset
module serial_xcvr (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tx_pin_in,
    output reg tx_pin_out,
    output reg tx_pin_oe,
    input wire rx_pin_in,
    output reg rx_pin_out,
    output reg rx_pin_oe,
    output reg rx_pullup_en,
    output reg tx_gpio_in,
    output reg rx_gpio_in
);

localparam TX_IDLE = 1'b0;
localparam TX_SHIFT = 1'b1;
localparam RX_IDLE = 2'd0;
localparam RX_START = 2'd1;
localparam RX_DATA = 2'd2;
localparam [7:0] CSB_RST = `CSB_RESET;

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] tx_buf_ff;
reg tx_pend_ff;
reg [7:0] rx_buf_ff;
reg rx_ninth_bit_ff;
reg rx_done_ff;
reg tx_done_ff;
reg data_empty_ff;
reg frame_err_ff;
reg overrun_ff;
reg ovr_pend_ff;
reg double_ff;
reg rx_en_ff;
reg tx_en_ff;
reg nine_ff;
reg tx_ninth_ff;
reg [11:0] baud_ff;
reg [3:0] port_ff;
reg [11:0] div_ff;
reg tick_ff;
reg [1:0] rx_sync_ff;
reg [1:0] txp_sync_ff;
// transmitter
reg tx_state_ff;
reg [10:0] tx_sh_ff;
reg [3:0] tx_left_ff;
reg [4:0] tx_cnt_ff;
reg tx_line_ff;
// receiver
reg [1:0] rx_state_ff;
reg [4:0] rx_cnt_ff;
reg [2:0] rx_smp_ff;
reg [3:0] rx_bit_ff;
reg [9:0] rx_sh_ff;

wire [4:0] ovs = double_ff ? `OVS_DOUBLE : `OVS_NORMAL;
wire [4:0] smp_a = double_ff ? `SMP_A_DOUBLE : `SMP_A_NORMAL;
wire rx_line = rx_sync_ff[1];
wire acc = psel && penable && !pready;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;
wire wr_data = wr && paddr == `OFS_DATA;
wire rd_data = rd && paddr == `OFS_DATA;
wire wr_csa = wr && paddr == `OFS_CSA;
wire mapped = paddr == `OFS_DATA || paddr == `OFS_CSA || paddr == `OFS_CSB ||
              paddr == `OFS_BAUD || paddr == `OFS_PORT;
wire [3:0] nbits = nine_ff ? 4'd11 : 4'd10;
wire tx_bit_end = tick_ff && tx_cnt_ff == ovs - 5'd1;
wire tx_frame_end = tx_state_ff == TX_SHIFT && tx_bit_end && tx_left_ff == 4'd1;
wire tx_load = tx_en_ff && (tx_pend_ff || wr_data) &&
               (tx_state_ff == TX_IDLE || tx_frame_end);
wire maj = (rx_smp_ff[0] & rx_smp_ff[1]) | (rx_smp_ff[0] & rx_smp_ff[2]) |
           (rx_smp_ff[1] & rx_smp_ff[2]);
wire rx_bit_end = tick_ff && rx_cnt_ff == ovs - 5'd1;
wire rx_complete = rx_state_ff == RX_DATA && rx_bit_end && rx_bit_ff == nbits - 4'd2;

// ----------------------------------------
// baud divider and pin synchronisers
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        div_ff <= 12'h000;
        tick_ff <= 1'b0;
        rx_sync_ff <= 2'b11;
        txp_sync_ff <= 2'b11;
    end else begin
        rx_sync_ff <= {rx_sync_ff[0], rx_pin_in};
        txp_sync_ff <= {txp_sync_ff[0], tx_pin_in};
        if (div_ff == 12'h000) begin
            div_ff <= baud_ff;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff - 12'h001;
            tick_ff <= 1'b0;
        end
    end
end

// ----------------------------------------
// apb slave and flags
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        tx_buf_ff <= 8'h00;
        tx_pend_ff <= 1'b0;
        rx_buf_ff <= 8'h00;
        rx_ninth_bit_ff <= CSB_RST[`CSB_RX_NINTH];
        rx_done_ff <= 1'b0;
        tx_done_ff <= 1'b0;
        data_empty_ff <= 1'b1;
        frame_err_ff <= 1'b0;
        overrun_ff <= 1'b0;
        ovr_pend_ff <= 1'b0;
        double_ff <= 1'b0;
        rx_en_ff <= 1'b0;
        tx_en_ff <= 1'b0;
        nine_ff <= 1'b0;
        tx_ninth_ff <= 1'b0;
        baud_ff <= `BAUD_RESET;
        port_ff <= 4'h0;
    end else begin
        pready <= acc;
        pslverr <= acc && !mapped;
        if (rd) begin
            case (paddr)
                `OFS_DATA: prdata <= {24'h000000, rx_buf_ff};
                `OFS_CSA: prdata <= {24'h000000, rx_done_ff, tx_done_ff, data_empty_ff,
                                     frame_err_ff, overrun_ff, 1'b0, double_ff, 1'b0};
                `OFS_CSB: prdata <= {27'h0000000, rx_en_ff, tx_en_ff, nine_ff,
                                     rx_ninth_bit_ff, tx_ninth_ff};
                `OFS_BAUD: prdata <= {20'h00000, baud_ff};
                `OFS_PORT: prdata <= {28'h0000000, port_ff};
                default: prdata <= 32'h00000000;
            endcase
        end
        if (wr && paddr == `OFS_CSB) begin
            rx_en_ff <= pwdata[`CSB_RX_EN];
            tx_en_ff <= pwdata[`CSB_TX_EN];
            nine_ff <= pwdata[`CSB_NINE];
            tx_ninth_ff <= pwdata[`CSB_TX_NINTH];
        end
        if (wr && paddr == `OFS_BAUD)
            baud_ff <= pwdata[11:0];
        if (wr && paddr == `OFS_PORT)
            port_ff <= pwdata[3:0];
        if (wr_csa)
            double_ff <= pwdata[`CSA_DOUBLE];
        // transmit buffer
        if (wr_data) begin
            tx_buf_ff <= pwdata[7:0];
            tx_pend_ff <= !tx_load;
        end else if (tx_load) begin
            tx_pend_ff <= 1'b0;
        end
        if (tx_load)
            data_empty_ff <= 1'b1;
        else if (wr_data)
            data_empty_ff <= 1'b0;
        // tx done: set wins over clear
        if (tx_frame_end && !tx_load && !tx_pend_ff)
            tx_done_ff <= 1'b1;
        else if (wr_data || (wr_csa && pwdata[`CSA_TX_DONE]))
            tx_done_ff <= 1'b0;
        // receive side
        if (rx_complete && !(rx_done_ff && !rd_data)) begin
            // stop bit not yet shifted: data sits one place up in 8-bit mode
            rx_buf_ff <= nine_ff ? rx_sh_ff[8:1] : rx_sh_ff[9:2];
            if (nine_ff)
                rx_ninth_bit_ff <= rx_sh_ff[9];
            frame_err_ff <= !maj;
            rx_done_ff <= 1'b1;
            // set by a read of buffered overrun wins over the clear
            overrun_ff <= rd_data && ovr_pend_ff;
            ovr_pend_ff <= 1'b0;
        end else begin
            if (rx_complete)
                ovr_pend_ff <= 1'b1;
            if (rd_data) begin
                rx_done_ff <= 1'b0;
                if (ovr_pend_ff || rx_complete)
                    overrun_ff <= 1'b1;
            end
        end
    end
end

// ----------------------------------------
// transmitter
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        tx_state_ff <= TX_IDLE;
        tx_sh_ff <= 11'h7FF;
        tx_left_ff <= 4'h0;
        tx_cnt_ff <= 5'd0;
        tx_line_ff <= 1'b1;
    end else begin
        if (tx_load) begin
            tx_state_ff <= TX_SHIFT;
            tx_cnt_ff <= 5'd0;
            tx_left_ff <= nbits;
            if (nine_ff)
                tx_sh_ff <= {1'b1, tx_ninth_ff, (wr_data ? pwdata[7:0] : tx_buf_ff), 1'b0};
            else
                tx_sh_ff <= {2'b11, (wr_data ? pwdata[7:0] : tx_buf_ff), 1'b0};
        end else if (tx_state_ff == TX_SHIFT) begin
            if (tick_ff) begin
                if (tx_cnt_ff == 5'd0)
                    tx_line_ff <= tx_sh_ff[0];
                if (tx_bit_end) begin
                    tx_cnt_ff <= 5'd0;
                    tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                    tx_left_ff <= tx_left_ff - 4'd1;
                    if (tx_left_ff == 4'd1)
                        tx_state_ff <= TX_IDLE;
                end else begin
                    tx_cnt_ff <= tx_cnt_ff + 5'd1;
                end
            end
        end else begin
            tx_line_ff <= 1'b1;
        end
    end
end

// ----------------------------------------
// receiver
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        rx_state_ff <= RX_IDLE;
        rx_cnt_ff <= 5'd0;
        rx_smp_ff <= 3'b111;
        rx_bit_ff <= 4'h0;
        rx_sh_ff <= 10'h000;
    end else if (!rx_en_ff) begin
        rx_state_ff <= RX_IDLE;
    end else if (tick_ff) begin
        case (rx_state_ff)
            RX_IDLE: begin
                if (!rx_line) begin
                    rx_state_ff <= RX_START;
                    rx_cnt_ff <= 5'd1;
                end
            end
            RX_START, RX_DATA: begin
                if (rx_cnt_ff >= smp_a && rx_cnt_ff <= smp_a + 5'd2)
                    rx_smp_ff <= {rx_smp_ff[1:0], rx_line};
                if (rx_bit_end) begin
                    rx_cnt_ff <= 5'd0;
                    if (rx_state_ff == RX_START) begin
                        if (maj)
                            rx_state_ff <= RX_IDLE;
                        else begin
                            rx_state_ff <= RX_DATA;
                            rx_bit_ff <= 4'h0;
                        end
                    end else begin
                        rx_sh_ff <= {maj, rx_sh_ff[9:1]};
                        rx_bit_ff <= rx_bit_ff + 4'd1;
                        if (rx_complete) begin
                            rx_state_ff <= RX_IDLE;
                            rx_sh_ff <= nine_ff ? rx_sh_ff : {1'b0, rx_sh_ff[9:1]};
                        end
                    end
                end else begin
                    rx_cnt_ff <= rx_cnt_ff + 5'd1;
                end
            end
            default: rx_state_ff <= RX_IDLE;
        endcase
    end
end

// ----------------------------------------
// pin control
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        tx_pin_out <= 1'b1;
        tx_pin_oe <= 1'b0;
        rx_pin_out <= 1'b0;
        rx_pin_oe <= 1'b0;
        rx_pullup_en <= 1'b0;
        tx_gpio_in <= 1'b1;
        rx_gpio_in <= 1'b1;
    end else begin
        tx_pin_out <= tx_en_ff ? tx_line_ff : port_ff[`PORT_OUT_TX];
        tx_pin_oe <= tx_en_ff | port_ff[`PORT_DIR_TX];
        rx_pin_out <= port_ff[`PORT_OUT_RX];
        rx_pin_oe <= !rx_en_ff && port_ff[`PORT_DIR_RX];
        rx_pullup_en <= (rx_en_ff || !port_ff[`PORT_DIR_RX]) && port_ff[`PORT_OUT_RX];
        tx_gpio_in <= txp_sync_ff[1];
        rx_gpio_in <= rx_line;
    end
end

endmodule // serial_xcvr

//--- serial_xcvr_asserts.sv
// port assertions of the serial transceiver
`timescale 1ns/100ps
`include "serial_map.vh"
module serial_xcvr_asserts (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire tx_pin_out,
    input wire tx_pin_oe,
    input wire rx_pin_oe,
    input wire rx_pullup_en
);
    reg txen_ff;
    reg receiver_enable_ff;
    reg dir_tx_ff;
    reg out_rx_ff;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    // ----------------------------------------
    // mirror of enables and port bits
    // ----------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txen_ff <= 1'b0;
            receiver_enable_ff <= 1'b0;
            dir_tx_ff <= 1'b0;
            out_rx_ff <= 1'b0;
        end else if (wr_ok && paddr == `OFS_CSB) begin
            txen_ff <= pwdata[`CSB_TX_EN];
            receiver_enable_ff <= pwdata[`CSB_RX_EN];
        end else if (wr_ok && paddr == `OFS_PORT) begin
            dir_tx_ff <= pwdata[`PORT_DIR_TX];
            out_rx_ff <= pwdata[`PORT_OUT_RX];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_access_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("long ready");
    a_err_map: assert property (pready |-> pslverr == !(paddr == `OFS_DATA || paddr == `OFS_CSA ||
        paddr == `OFS_CSB || paddr == `OFS_BAUD || paddr == `OFS_PORT))
        else $error("bad error");
    a_tx_forced: assert property (txen_ff && $past(txen_ff, 2) |-> tx_pin_oe)
        else $error("tx not output");
    a_tx_free: assert property (!txen_ff && !dir_tx_ff && !$past(txen_ff, 2) && !$past(dir_tx_ff, 2)
        |-> !tx_pin_oe)
        else $error("tx driven");
    a_rx_forced: assert property (receiver_enable_ff && $past(receiver_enable_ff, 2) |-> !rx_pin_oe)
        else $error("rx driven");
    a_rx_pullup: assert property (receiver_enable_ff && out_rx_ff && $past(receiver_enable_ff, 2) && $past(out_rx_ff, 2)
        |-> rx_pullup_en)
        else $error("no pullup");
    a_bit_width: assert property ($fell(tx_pin_out) && tx_pin_oe && txen_ff && $past(txen_ff, 3)
        |-> !tx_pin_out [*8])
        else $error("short bit");
    c_err: cover property (pready && pslverr);
    c_frame: cover property ($fell(tx_pin_out) && txen_ff);
    c_pullup: cover property (receiver_enable_ff && rx_pullup_en);
endmodule // serial_xcvr_asserts
bind serial_xcvr serial_xcvr_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_oe(rx_pin_oe), .rx_pullup_en(rx_pullup_en));

//--- serial_peer.sv
// remote serial node on the tx and rx lines
`timescale 1ns/100ps
module serial_peer (
    input wire clk,
    input wire line_in,
    input wire listen,
    output reg line_out
);
    int bit_clks = 32;
    bit nine = 1'b0;
    int rxq[$];
    int v;
    initial line_out = 1'b1;
    task automatic hold(input logic lvl, input int n);
        line_out <= lvl;
        repeat (n) @(posedge clk);
    endtask
    // start low, data lsb first, stop, one idle bit
    task automatic send(input int val, input logic stop);
        hold(1'b0, bit_clks);
        for (int i = 0; i < (nine ? 9 : 8); i++) hold(val[i], bit_clks);
        hold(stop, bit_clks);
        hold(1'b1, bit_clks);
    endtask
    // low pulse gone before the middle samples
    task automatic glitch();
        hold(1'b0, bit_clks / 4);
        hold(1'b1, 2 * bit_clks);
    endtask
    // decode data and stop at mid bit
    always begin
        @(negedge line_in iff listen);
        repeat (bit_clks / 2) @(posedge clk);
        v = 0;
        for (int i = 0; i <= (nine ? 9 : 8); i++) begin
            repeat (bit_clks) @(posedge clk);
            v[i] = line_in;
        end
        rxq.push_back(v);
    end
endmodule // serial_peer

//--- tb_async_serial_transceiver.sv
// self-checking bench of the serial transceiver
`timescale 1ns/100ps
`include "serial_map.vh"
module tb_async_serial_transceiver;
    localparam logic [31:0] RXD = 32'h1 << `CSA_RX_DONE;
    localparam logic [31:0] TXD = 32'h1 << `CSA_TX_DONE;
    localparam logic [31:0] EMP = 32'h1 << `CSA_DATA_EMPTY;
    localparam logic [31:0] FER = 32'h1 << `CSA_FRAME_ERR;
    localparam logic [31:0] OVR = 32'h1 << `CSA_OVERRUN;
    localparam logic [31:0] ENS = (32'h1 << `CSB_RX_EN) | (32'h1 << `CSB_TX_EN);
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic tog = 1'b0;
    logic [31:0] rq;
    logic re;
    logic [15:0] pin_tab [4] = '{16'h00F6, 16'h0081, 16'h1824, 16'h18A5};
    wire [31:0] prdata;
    wire pready, pslverr, tx_pin_out, tx_pin_oe, rx_pin_out, rx_pin_oe, rx_pullup_en, peer_out;
    wire tx_gpio, rx_gpio;
    wire tx_line = tx_pin_oe ? tx_pin_out : tog;
    wire rx_line = rx_pin_oe ? rx_pin_out : peer_out;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int exp_q[$];
    int b;
    serial_xcvr DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_pin_in(tx_line), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_line),
        .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .rx_pullup_en(rx_pullup_en), .tx_gpio_in(tx_gpio),
        .rx_gpio_in(rx_gpio));
    serial_peer peer (.clk(clk), .line_in(tx_line), .listen(tx_pin_oe), .line_out(peer_out));
    always #5 clk = ~clk;
    always @(posedge clk) tog <= ~tog;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            end_sim();
        end
    end
    // ----------------------------------------
    // bus, compare and closing tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("compared %0d, mismatched %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_ser();
        while (peer.rxq.size() == 0) @(posedge clk);
        chk_reg(exp_q.pop_front(), peer.rxq.pop_front());
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_csa(input logic [31:0] m);
        do apb(1'b0, `OFS_CSA, 32'h0); while ((rq & m) !== m);
    endtask
    task automatic tx_one(input int v);
        exp_q.push_back(peer.nine ? (v & 32'h1FF) | 32'h200 : (v & 32'hFF) | 32'h100);
        apb(1'b1, `OFS_DATA, v & 32'hFF);
    endtask
    task automatic rx_one(input int v, input logic stop);
        peer.send(v, stop);
        wait_csa(RXD);
        chk_reg(stop ? 32'h0 : FER, rq & FER);
        apb(1'b0, `OFS_DATA, 32'h0);
        chk_reg(v & 32'hFF, rq);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(32'h0, rq & RXD);
    endtask
    initial begin
        b = $urandom(12062);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(`CSA_RESET, rq);
        apb(1'b0, 12'h020, 32'h0);
        chk_reg(32'h1, re);
        $display("reset done");
        apb(1'b1, `OFS_BAUD, 32'h1);
        apb(1'b1, `OFS_CSB, ENS);
        b = $urandom_range(0, 255);
        tx_one(b);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(EMP, rq & EMP);
        tx_one(b ^ 32'hFF);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(32'h0, rq & (EMP | TXD));
        chk_ser();
        chk_ser();
        wait_csa(TXD);
        chk_reg(EMP, rq & EMP);
        apb(1'b1, `OFS_CSA, TXD);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(EMP, rq);
        $display("transmit done");
        for (int i = 0; i < 4; i++) rx_one($urandom_range(0, 255), 1'b1);
        rx_one(32'hA5, 1'b0);
        rx_one(32'h3C, 1'b1);
        peer.glitch();
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(32'h0, rq & RXD);
        rx_one(32'h81, 1'b1);
        $display("receive done");
        peer.send(32'h11, 1'b1);
        peer.send(32'h22, 1'b1);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(RXD, rq & (RXD | OVR));
        apb(1'b0, `OFS_DATA, 32'h0);
        chk_reg(32'h11, rq);
        apb(1'b0, `OFS_CSA, 32'h0);
        chk_reg(OVR, rq & (RXD | OVR));
        rx_one(32'h33, 1'b1);
        chk_reg(32'h0, rq & OVR);
        $display("overrun done");
        peer.nine = 1'b1;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `OFS_CSB, ENS | (32'h1 << `CSB_NINE) | k);
            tx_one(32'h5A | (k << 8));
            chk_ser();
            peer.send(32'hA5 | ((1 - k) << 8), 1'b1);
            wait_csa(RXD);
            apb(1'b0, `OFS_CSB, 32'h0);
            chk_reg((1 - k) << `CSB_RX_NINTH, rq & (32'h1 << `CSB_RX_NINTH));
            apb(1'b0, `OFS_DATA, 32'h0);
            chk_reg(32'hA5, rq);
        end
        peer.nine = 1'b0;
        $display("nine bit done");
        apb(1'b1, `OFS_CSB, ENS);
        apb(1'b1, `OFS_CSA, 32'h1 << `CSA_DOUBLE);
        peer.bit_clks = 16;
        tx_one(32'hC3);
        chk_ser();
        rx_one(32'h5E, 1'b1);
        $display("double speed done");
        foreach (pin_tab[i]) begin
            apb(1'b1, `OFS_CSB, pin_tab[i][15:8]);
            apb(1'b1, `OFS_PORT, pin_tab[i][7:4]);
            repeat (6) @(posedge clk);
            chk_reg(pin_tab[i][2:0], {tx_pin_oe, rx_pin_oe, rx_pullup_en});
            chk_reg({rx_line, pin_tab[i][7]}, {rx_gpio, rx_pin_out});
            if (tx_pin_oe) chk_reg(32'h1, tx_gpio);
        end
        $display("pins done");
        end_sim();
    end
endmodule // tb_async_serial_transceiver
